// ### rtl/asfw_map.svh
// Offsets, field positions and reset values of the axis status words
`ifndef ASFW_MAP_SVH
`define ASFW_MAP_SVH
`define ASFW_AXES 8
`define ASFW_SLOT_STRIDE 8
`define ASFW_LOCK_BUSY_BASE 11
`define ASFW_COMPLETION_BASE 12
`define ASFW_OFF_LOCK_BUSY 8'h00
`define ASFW_OFF_COMPLETION 8'h04
`define ASFW_OFF_IRQ_STATUS 8'h08
`define ASFW_OFF_IRQ_MASK 8'h0c
`define ASFW_OFF_SLOT 8'h10
`define ASFW_OFF_CONNECTED 8'h14
`define ASFW_OFF_WORD_LOC 8'h18
`define ASFW_LOCK_LSB 0
`define ASFW_BUSY_LSB 8
`define ASFW_OP_DONE_LSB 0
`define ASFW_HOME_DONE_LSB 8
`define ASFW_WORD_RESET 16'h0000
`define ASFW_MASK_RESET 16'h0000
`define ASFW_RESP_OKAY 2'b00
`define ASFW_RESP_SLVERR 2'b10
`endif

// ### rtl/asfw_pkg.sv
// Types shared by the axis status word block
package asfw_pkg;
    typedef struct packed {
        logic [7:0] busy;
        logic [7:0] lock;
    } asfw_lock_busy_type;
    typedef struct packed {
        logic [7:0] home_done;
        logic [7:0] op_done;
    } asfw_completion_type;
    typedef struct packed {
        logic [7:0] servo_locked;
        logic [7:0] moving;
        logic [7:0] cmd_finished;
        logic [7:0] in_width;
        logic [7:0] auto_seq;
        logic [7:0] seq_all_done;
        logic [7:0] home_finished;
        logic [7:0] control_start;
    } asfw_axis_in_type;
    typedef enum logic [1:0] {
        ASFW_RD_IDLE = 2'b01,
        ASFW_RD_RESP = 2'b10
    } asfw_rd_state_type;
endpackage

// ### rtl/asfw_status_words.sv
// Axis lock/busy and completion status words with AXI4-Lite access
`timescale 1ns/1ns
`include "asfw_map.svh"
module asfw_status_words
    import asfw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire asfw_axis_in_type axis_in,
    input wire logic [7:0] axis_connected,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output asfw_lock_busy_type lock_busy_word,
    output asfw_completion_type completion_word
);

    // Word location of a status word for a given slot
    function automatic logic [7:0] word_loc(input logic [7:0] base, input logic [1:0] slot);
        word_loc = base + 8'(`ASFW_SLOT_STRIDE) * {6'h0, slot};
    endfunction

    // ************************************************************
    // Axis flags
    // ************************************************************
    logic [7:0] next_op_done;
    logic [7:0] next_home_done;
    logic [7:0] op_event;
    logic [7:0] home_event;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic [1:0] slot;
    logic [15:0] clr_bits;
    logic do_write;
    logic [7:0] waddr;

    always_comb begin
        // Auto runs finish only when the whole table sequence is done
        op_event = axis_in.cmd_finished & axis_in.in_width
            & (~axis_in.auto_seq | axis_in.seq_all_done);
        home_event = axis_in.home_finished;
        // Start of a new control clears; a same-cycle finish wins
        next_op_done = ((completion_word.op_done & ~axis_in.control_start) | op_event)
            & axis_connected;
        next_home_done = ((completion_word.home_done & ~axis_in.control_start) | home_event)
            & axis_connected;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_busy_word <= `ASFW_WORD_RESET;
            completion_word <= `ASFW_WORD_RESET;
        end else begin
            lock_busy_word.lock <= axis_in.servo_locked & axis_connected;
            lock_busy_word.busy <= axis_in.moving & axis_connected;
            completion_word.op_done <= next_op_done;
            completion_word.home_done <= next_home_done;
        end
    end

    a_op_done_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        completion_word.op_done[0] && !axis_in.control_start[0] && axis_connected[0]
        |=> completion_word.op_done[0])
        else $error("Op done dropped early");
    a_home_done_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        completion_word.home_done[7] && !axis_in.control_start[7] && axis_connected[7]
        |=> completion_word.home_done[7])
        else $error("Home done dropped early");
    a_op_done_set: assert property (@(posedge aclk) disable iff (!aresetn)
        axis_in.cmd_finished[0] && axis_in.in_width[0] && !axis_in.auto_seq[0]
        && axis_connected[0] |=> completion_word.op_done[0])
        else $error("Op done not set");
    a_auto_wait_seq: assert property (@(posedge aclk) disable iff (!aresetn)
        !completion_word.op_done[2] && axis_in.auto_seq[2] && !axis_in.seq_all_done[2]
        |=> !completion_word.op_done[2])
        else $error("Auto done before sequence");
    a_home_set: assert property (@(posedge aclk) disable iff (!aresetn)
        axis_in.home_finished[7] && axis_connected[7]
        |=> completion_word.home_done[7])
        else $error("Home done not set");
    a_lock_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn)
        |-> lock_busy_word.lock == ($past(axis_in.servo_locked) & $past(axis_connected)))
        else $error("Lock flags wrong");
    a_busy_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn)
        |-> lock_busy_word.busy == ($past(axis_in.moving) & $past(axis_connected)))
        else $error("Busy flags wrong");
    a_unconn_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(axis_connected[7]) && $past(aresetn)
        |-> !completion_word.op_done[7] && !completion_word.home_done[7]
        && !lock_busy_word.busy[7] && !lock_busy_word.lock[7])
        else $error("Unconnected axis flag set");

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= `ASFW_WORD_RESET;
        end else begin
            // A new event wins over a write-one clear in the same cycle
            irq_status <= (irq_status & ~clr_bits)
                | {home_event & ~completion_word.home_done & axis_connected,
                   op_event & ~completion_word.op_done & axis_connected};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    always_comb begin
        do_write = aw_held && w_held && !s_axi_bvalid;
        waddr = aw_addr_q;
        clr_bits = 16'h0000;
        if (do_write && waddr == `ASFW_OFF_IRQ_STATUS) begin
            clr_bits = {w_strb_q[1] ? w_data_q[15:8] : 8'h00,
                        w_strb_q[0] ? w_data_q[7:0] : 8'h00};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ASFW_RESP_OKAY;
            irq_mask <= `ASFW_MASK_RESET;
            slot <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `ASFW_RESP_OKAY;
                unique case (waddr)
                    `ASFW_OFF_IRQ_MASK: begin
                        if (w_strb_q[0]) irq_mask[7:0] <= w_data_q[7:0];
                        if (w_strb_q[1]) irq_mask[15:8] <= w_data_q[15:8];
                    end
                    `ASFW_OFF_SLOT: begin
                        if (w_strb_q[0]) slot <= w_data_q[1:0];
                    end
                    `ASFW_OFF_LOCK_BUSY, `ASFW_OFF_COMPLETION, `ASFW_OFF_IRQ_STATUS,
                    `ASFW_OFF_CONNECTED, `ASFW_OFF_WORD_LOC: begin
                    end
                    default: s_axi_bresp <= `ASFW_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    asfw_rd_state_type rd_state;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= ASFW_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ASFW_RESP_OKAY;
        end else begin
            unique case (rd_state)
                ASFW_RD_IDLE: begin
                    s_axi_arready <= !s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready) begin
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= `ASFW_RESP_OKAY;
                        rd_state <= ASFW_RD_RESP;
                        unique case (s_axi_araddr[7:0])
                            `ASFW_OFF_LOCK_BUSY: s_axi_rdata <= {16'h0000, lock_busy_word};
                            `ASFW_OFF_COMPLETION: s_axi_rdata <= {16'h0000, completion_word};
                            `ASFW_OFF_IRQ_STATUS: s_axi_rdata <= {16'h0000, irq_status};
                            `ASFW_OFF_IRQ_MASK: s_axi_rdata <= {16'h0000, irq_mask};
                            `ASFW_OFF_SLOT: s_axi_rdata <= {30'h0, slot};
                            `ASFW_OFF_CONNECTED: s_axi_rdata <= {24'h0, axis_connected};
                            `ASFW_OFF_WORD_LOC: begin
                                // Input word numbers of both words for this slot
                                s_axi_rdata <= {16'h0000,
                                    word_loc(8'(`ASFW_COMPLETION_BASE), slot),
                                    word_loc(8'(`ASFW_LOCK_BUSY_BASE), slot)};
                            end
                            default: begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= `ASFW_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                ASFW_RD_RESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rd_state <= ASFW_RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Completion clear, interrupt and bus checks
    // ************************************************************
    a_op_clear_start: assert property (@(posedge aclk) disable iff (!aresetn)
        completion_word.op_done[2] && axis_in.control_start[2] && !op_event[2]
        |=> !completion_word.op_done[2])
        else $error("Op done not cleared by start");
    a_home_clear_start: assert property (@(posedge aclk) disable iff (!aresetn)
        completion_word.home_done[7] && axis_in.control_start[7] && !home_event[7]
        |=> !completion_word.home_done[7])
        else $error("Home done not cleared by start");
    a_start_event_win: assert property (@(posedge aclk) disable iff (!aresetn)
        op_event[0] && axis_in.control_start[0] && axis_connected[0]
        |=> completion_word.op_done[0])
        else $error("Finish lost to start");
    a_reset_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn)
        |-> completion_word == `ASFW_WORD_RESET && lock_busy_word == `ASFW_WORD_RESET && !irq)
        else $error("Flags not cleared by reset");
    a_irq_set: assert property (@(posedge aclk) disable iff (!aresetn)
        !completion_word.op_done[0] && op_event[0] && axis_connected[0]
        |=> irq_status[0])
        else $error("Completion event not latched");
    a_irq_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_status[0] && !clr_bits[0]
        |=> irq_status[0])
        else $error("Status bit lost");
    a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn)
        |-> irq == (|($past(irq_status) & $past(irq_mask))))
        else $error("Interrupt level wrong");
    a_resp_after_both: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(s_axi_bvalid)
        |-> $past(aw_held) && $past(w_held))
        else $error("Write answered early");
    a_no_accept_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("Write taken during response");
    a_no_ar_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid
        |-> !s_axi_arready)
        else $error("Read taken during response");
    a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid
        |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("Read data upper half set");

endmodule

// ### tb/asfw_host_model.sv
// AXI4-Lite host model that reads and writes the status words
`timescale 1ns/1ns
module asfw_host_model;
    // ************************
    // Bounded wait expiry
    // ************************
    task automatic expire(input int n);
        if (n >= 64) begin
            tb_top.errors++;
            tb_top.conclude();
        end
    endtask

    // ************************
    // Bus cycles
    // ************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic got_a;
        logic got_w;
        n = 0;
        got_a = 1'b0;
        got_w = 1'b0;
        @(posedge tb_top.aclk);
        tb_top.s_axi_awaddr <= 32'(a);
        tb_top.s_axi_awvalid <= 1'b1;
        tb_top.s_axi_wdata <= d;
        tb_top.s_axi_wstrb <= 4'hf;
        tb_top.s_axi_wvalid <= 1'b1;
        tb_top.s_axi_bready <= 1'b1;
        while (!(got_a && got_w)) begin
            @(posedge tb_top.aclk);
            n++;
            expire(n);
            if (!got_a && tb_top.s_axi_awready === 1'b1) begin
                got_a = 1'b1;
                tb_top.s_axi_awvalid <= 1'b0;
            end
            if (!got_w && tb_top.s_axi_wready === 1'b1) begin
                got_w = 1'b1;
                tb_top.s_axi_wvalid <= 1'b0;
            end
        end
        while (tb_top.s_axi_bvalid !== 1'b1) begin
            @(posedge tb_top.aclk);
            n++;
            expire(n);
        end
        r = tb_top.s_axi_bresp;
        tb_top.s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge tb_top.aclk);
        tb_top.s_axi_araddr <= 32'(a);
        tb_top.s_axi_arvalid <= 1'b1;
        tb_top.s_axi_rready <= 1'b1;
        do begin
            @(posedge tb_top.aclk);
            n++;
            expire(n);
        end while (tb_top.s_axi_arready !== 1'b1);
        tb_top.s_axi_arvalid <= 1'b0;
        do begin
            @(posedge tb_top.aclk);
            n++;
            expire(n);
        end while (tb_top.s_axi_rvalid !== 1'b1);
        d = tb_top.s_axi_rdata;
        r = tb_top.s_axi_rresp;
        tb_top.s_axi_rready <= 1'b0;
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the axis status words
`timescale 1ns/1ns
`include "asfw_map.svh"
module tb_top
    import asfw_pkg::*;
;
    logic aclk;
    logic aresetn;
    asfw_axis_in_type axis_in;
    asfw_axis_in_type lvl;
    logic [7:0] axis_connected;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    asfw_lock_busy_type lock_busy_word;
    asfw_completion_type completion_word;
    int errors;
    int n_tests;

    asfw_host_model host_u();
    asfw_status_words dut_u(.aclk(aclk), .aresetn(aresetn), .axis_in(axis_in),
        .axis_connected(axis_connected), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .irq(irq), .lock_busy_word(lock_busy_word),
        .completion_word(completion_word));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // ************************
    // Helpers
    // ************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        host_u.rd(a, d, r);
        chk(d, exp);
        chk(32'(r), 32'(`ASFW_RESP_OKAY));
    endtask

    task automatic lv(input logic [7:0] lock, input logic [7:0] mov);
        lvl.servo_locked = lock;
        lvl.moving = mov;
        @(posedge aclk);
        axis_in <= lvl;
        repeat (2) @(posedge aclk);
    endtask

    // One-cycle event: finished, in width, auto, all tables, home, start
    task automatic ev(input logic [7:0] f, w, au, al, h, s);
        @(posedge aclk);
        axis_in <= {lvl.servo_locked, lvl.moving, f, w, au, al, h, s};
        @(posedge aclk);
        axis_in <= lvl;
        repeat (2) @(posedge aclk);
    endtask

    task automatic conclude();
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ************************
    // Main sequence
    // ************************
    initial begin
        {aresetn, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        axis_in = '0;
        lvl = '0;
        axis_connected = 8'hff;
        errors = 0;
        n_tests = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'(completion_word), 32'h0);
        for (int s = 0; s < 4; s++) begin
            host_u.wr(`ASFW_OFF_SLOT, 32'(s), r);
            rchk(`ASFW_OFF_WORD_LOC, {16'h0, 8'(12 + 8 * s), 8'(11 + 8 * s)});
        end
        lv(8'h81, 8'h42);
        chk(32'(lock_busy_word), 32'h4281);
        rchk(`ASFW_OFF_LOCK_BUSY, 32'h4281);
        axis_connected <= 8'h0f;
        lv(8'h81, 8'h00);
        rchk(`ASFW_OFF_LOCK_BUSY, 32'h0001);
        axis_connected <= 8'hff;
        ev(8'h03, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
        ev(8'h04, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00);
        rchk(`ASFW_OFF_COMPLETION, 32'h0001);
        ev(8'h04, 8'h04, 8'h04, 8'h04, 8'h00, 8'h00);
        ev(8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00);
        repeat (4) @(posedge aclk);
        chk(32'(completion_word), 32'h8005);
        chk(32'(irq), 32'h0);
        rchk(`ASFW_OFF_IRQ_STATUS, 32'h8005);
        host_u.wr(`ASFW_OFF_IRQ_MASK, 32'h0000ffff, r);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        host_u.wr(`ASFW_OFF_IRQ_STATUS, 32'h0000ffff, r);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        ev(8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h85);
        rchk(`ASFW_OFF_COMPLETION, 32'h0001);
        axis_connected <= 8'h7f;
        ev(8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00);
        rchk(`ASFW_OFF_COMPLETION, 32'h0001);
        rchk(`ASFW_OFF_IRQ_STATUS, 32'h0000);
        axis_connected <= 8'hff;
        host_u.wr(`ASFW_OFF_LOCK_BUSY, 32'h0000ffff, r);
        chk(32'(r), 32'(`ASFW_RESP_OKAY));
        rchk(`ASFW_OFF_LOCK_BUSY, 32'h0081);
        host_u.wr(8'h40, 32'h1, r);
        chk(32'(r), 32'(`ASFW_RESP_SLVERR));
        host_u.rd(8'h40, d, r);
        chk({d[29:0], r}, 32'(`ASFW_RESP_SLVERR));
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`ASFW_OFF_COMPLETION, 32'h0);
        chk(32'(irq), 32'h0);
        rchk(`ASFW_OFF_IRQ_MASK, 32'h0);
        rchk(`ASFW_OFF_SLOT, 32'h0);
        rchk(`ASFW_OFF_LOCK_BUSY, 32'h0081);
        rchk(`ASFW_OFF_CONNECTED, 32'h00ff);
        conclude();
    end
endmodule
